// ---- hw/cfgpin_pkg.sv ----
// Overview of operation
// - Optional pins with option off act as user I/O, tri-stated and pulled up in configuration
// - Active-serial tri-state option floats clock, data in, select, data out in user mode
// - Start-up clock option times initialization from the user start-up clock pin
// - Init-done floats while config_start_n is low and as configuration begins
// - Init-done is pulled low once its option bit loads in the first frame
// - Init-done is released when initialization completes and user mode begins
// - Enabled global output enable driven low tri-states every I/O pin
// - Global output enable high lets every I/O pin follow its programmed enable
// - Enabled global register clear driven low clears the user I/O and optional-pin output and enable registers
// - Global register clear high lets registers follow their programmed clear and preset
// - Scan instruction and data shift in from test data in on test clock rise
// - Test data out shifts on test clock fall and floats when not shifting
// - Mode select sampled on test clock rise; state moves on the following fall
package cfgpin_pkg;
  // Register byte offsets
  localparam logic [5:0] OFF_OPTIONS = 6'h00;
  localparam logic [5:0] OFF_CMD = 6'h04;
  localparam logic [5:0] OFF_STATUS = 6'h08;
  localparam logic [5:0] OFF_IO_OE = 6'h0C;
  localparam logic [5:0] OFF_IO_OUT = 6'h10;
  localparam logic [5:0] OFF_IO_IN = 6'h14;
  localparam logic [5:0] OFF_SCAN_IR = 6'h18;
  localparam logic [5:0] OFF_SCAN_DR = 6'h1C;
  localparam logic [5:0] OFF_OPT_IO = 6'h20;
  // Option bit positions
  localparam int OPT_STARTUP_CLK = 0;
  localparam int OPT_INIT_DONE = 1;
  localparam int OPT_GLOBAL_OE = 2;
  localparam int OPT_GLOBAL_CLR = 3;
  localparam int OPT_AS_TRISTATE = 4;
  localparam int OPT_W = 5;
  // Command bit positions
  localparam int CMD_OPTIONS_LOADED = 0;
  localparam int CMD_DATA_COMPLETE = 1;
  // Optional pin indices
  localparam int PIN_STARTUP_CLK = 0;
  localparam int PIN_INIT_DONE = 1;
  localparam int PIN_GLOBAL_OE = 2;
  localparam int PIN_GLOBAL_CLR = 3;
  // Active-serial output pin indices
  localparam int AS_CLK = 0;
  localparam int AS_SELECT = 1;
  localparam int AS_DATA_OUT = 2;
  // Reset values and counts
  localparam logic [4:0] OPTIONS_RESET = 5'h00;
  localparam logic [2:0] AS_IDLE_LEVEL = 3'h6;
  localparam int INIT_TICKS = 16;
  localparam real STARTUP_TICK_NS = 200.0;
  localparam real CLK_PERIOD_NS = 25.0;
  localparam int STARTUP_DIV = int'(STARTUP_TICK_NS / CLK_PERIOD_NS);
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  // Configuration states
  typedef enum logic [1:0] {CFG_RESET, CFG_LOAD, CFG_INIT, CFG_USER} cfgpin_cfg_t;
  // Scan port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } cfgpin_tap_t;
endpackage

// ---- hw/cfgpin_top.sv ----
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module cfgpin_top #(
  parameter int IO_W = 8,
  parameter int IR_W = 10,
  parameter int DR_W = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Configuration control pin
  input wire logic config_start_n,
  // Active-serial pins
  input wire logic config_serial_in,
  output logic [2:0] as_out,
  output logic [2:0] as_oe,
  output logic config_serial_in_en,
  // Optional pins: start-up clock, init-done, global output enable, global clear
  input wire logic [3:0] opt_pin_in,
  output logic [3:0] opt_pin_out,
  output logic [3:0] opt_pin_oe,
  output logic [3:0] opt_pin_pullup,
  // General user I/O
  input wire logic [IO_W-1:0] io_in,
  output logic [IO_W-1:0] io_out,
  output logic [IO_W-1:0] io_oe,
  // Boundary-scan pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo_out,
  output logic tdo_oe,
  // Status
  output logic user_mode
);
  localparam int SYNC_W = IO_W + 10;

  // Two-flop synchronisers for every pin input
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {io_in, opt_pin_in, trst_n, tdi, tms, tck, config_serial_in, config_start_n};
      sync2 <= sync1;
    end
  end

  // Synchronised pin levels
  logic s_cfg_start_n;
  logic s_serial_in;
  logic s_tck;
  logic s_tms;
  logic s_tdi;
  logic s_trst_n;
  logic [3:0] s_opt;
  logic [IO_W-1:0] s_io;
  assign s_cfg_start_n = sync2[0];
  assign s_serial_in = sync2[1];
  assign s_tck = sync2[2];
  assign s_tms = sync2[3];
  assign s_tdi = sync2[4];
  assign s_trst_n = sync2[5];
  assign s_opt = sync2[9:6];
  assign s_io = sync2[SYNC_W-1:10];

  // Edge detection on synchronised clocks
  logic tck_d;
  logic startup_d;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tck_d <= 1'b0;
      startup_d <= 1'b0;
    end
    else
    begin
      tck_d <= s_tck;
      startup_d <= s_opt[cfgpin_pkg::PIN_STARTUP_CLK];
    end
  end
  logic tck_rise;
  logic tck_fall;
  logic startup_rise;
  assign tck_rise = s_tck & ~tck_d;
  assign tck_fall = ~s_tck & tck_d;
  assign startup_rise = s_opt[cfgpin_pkg::PIN_STARTUP_CLK] & ~startup_d;

  // Register state
  logic [cfgpin_pkg::OPT_W-1:0] options;
  logic [IO_W-1:0] io_oe_reg;
  logic [IO_W-1:0] io_out_reg;
  logic [3:0] opt_io_out;
  logic [3:0] opt_io_oe;
  logic options_loaded;
  cfgpin_pkg::cfgpin_cfg_t cfg_state;
  logic [IR_W-1:0] ir_hold;
  logic [DR_W-1:0] dr_hold;

  // Bus request decode; a request is taken in the cycle waitrequest is low
  logic bus_take;
  logic wr_take;
  assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_take = avs_write & ~avs_waitrequest;

  // Global override levels, only honoured when their options are on
  logic global_oe_off;
  logic global_clear;
  assign global_oe_off = options[cfgpin_pkg::OPT_GLOBAL_OE]
                       & ~s_opt[cfgpin_pkg::PIN_GLOBAL_OE];
  assign global_clear = options[cfgpin_pkg::OPT_GLOBAL_CLR]
                      & ~s_opt[cfgpin_pkg::PIN_GLOBAL_CLR];

  // Wait state: one cycle of waitrequest low answers each request
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      avs_waitrequest <= 1'b1;
    else if ((avs_read | avs_write) & avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // Read data mux, prepared while waitrequest is high
  logic [31:0] next_readdata;
  always_comb
  begin
    next_readdata = '0;
    case (avs_address)
      cfgpin_pkg::OFF_OPTIONS: next_readdata[cfgpin_pkg::OPT_W-1:0] = options;
      cfgpin_pkg::OFF_STATUS:
        next_readdata[7:0] = {s_opt[cfgpin_pkg::PIN_GLOBAL_CLR],
                              s_opt[cfgpin_pkg::PIN_GLOBAL_OE],
                              s_serial_in, s_opt[cfgpin_pkg::PIN_INIT_DONE],
                              options_loaded, s_cfg_start_n, cfg_state};
      cfgpin_pkg::OFF_IO_OE: next_readdata[IO_W-1:0] = io_oe_reg;
      cfgpin_pkg::OFF_IO_OUT: next_readdata[IO_W-1:0] = io_out_reg;
      cfgpin_pkg::OFF_IO_IN: next_readdata[IO_W-1:0] = s_io;
      cfgpin_pkg::OFF_SCAN_IR: next_readdata[IR_W-1:0] = ir_hold;
      cfgpin_pkg::OFF_SCAN_DR: next_readdata[DR_W-1:0] = dr_hold;
      cfgpin_pkg::OFF_OPT_IO: next_readdata[11:0] = {s_opt, opt_io_oe, opt_io_out};
      default: next_readdata = '0;
    endcase
  end

  // Read data register, held until the next read request
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      avs_readdata <= '0;
    else if (avs_read & avs_waitrequest)
      avs_readdata <= next_readdata;
  end

  // Option register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      options <= cfgpin_pkg::OPTIONS_RESET;
    else if (wr_take && avs_address == cfgpin_pkg::OFF_OPTIONS)
      options <= avs_writedata[cfgpin_pkg::OPT_W-1:0];
  end

  // User I/O registers; the global clear beats any write
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      io_oe_reg <= '0;
      io_out_reg <= '0;
      opt_io_out <= '0;
      opt_io_oe <= '0;
    end
    else if (global_clear)
    begin
      io_oe_reg <= '0;
      io_out_reg <= '0;
      opt_io_out <= '0;
      opt_io_oe <= '0;
    end
    else if (wr_take)
    begin
      // Programmed behaviour while the clear is released
      if (avs_address == cfgpin_pkg::OFF_IO_OE)
        io_oe_reg <= avs_writedata[IO_W-1:0];
      if (avs_address == cfgpin_pkg::OFF_IO_OUT)
        io_out_reg <= avs_writedata[IO_W-1:0];
      if (avs_address == cfgpin_pkg::OFF_OPT_IO)
      begin
        opt_io_out <= avs_writedata[3:0];
        opt_io_oe <= avs_writedata[7:4];
      end
    end
  end

  // Internal start-up tick divider
  logic [$clog2(cfgpin_pkg::STARTUP_DIV+1)-1:0] div_cnt;
  logic div_tick;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt <= '0;
      div_tick <= 1'b0;
    end
    else if (div_cnt == $bits(div_cnt)'(cfgpin_pkg::STARTUP_DIV - 1))
    begin
      div_cnt <= '0;
      div_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      div_tick <= 1'b0;
    end
  end

  // Start-up tick source selection
  logic init_tick;
  assign init_tick = options[cfgpin_pkg::OPT_STARTUP_CLK] ? startup_rise : div_tick;

  // Configuration sequence
  logic [$clog2(cfgpin_pkg::INIT_TICKS+1)-1:0] init_cnt;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_state <= cfgpin_pkg::CFG_RESET;
      options_loaded <= 1'b0;
      init_cnt <= '0;
    end
    else if (!s_cfg_start_n)
    begin
      cfg_state <= cfgpin_pkg::CFG_RESET;
      options_loaded <= 1'b0;
      init_cnt <= '0;
    end
    else
    begin
      if (wr_take && avs_address == cfgpin_pkg::OFF_CMD
          && avs_writedata[cfgpin_pkg::CMD_OPTIONS_LOADED] && cfg_state == cfgpin_pkg::CFG_LOAD)
        options_loaded <= 1'b1;
      case (cfg_state)
        cfgpin_pkg::CFG_RESET: cfg_state <= cfgpin_pkg::CFG_LOAD;
        cfgpin_pkg::CFG_LOAD:
          if (wr_take && avs_address == cfgpin_pkg::OFF_CMD
              && avs_writedata[cfgpin_pkg::CMD_DATA_COMPLETE])
          begin
            cfg_state <= cfgpin_pkg::CFG_INIT;
            init_cnt <= '0;
          end
        cfgpin_pkg::CFG_INIT:
          if (init_tick)
          begin
            if (init_cnt == $bits(init_cnt)'(cfgpin_pkg::INIT_TICKS - 1))
              cfg_state <= cfgpin_pkg::CFG_USER;
            init_cnt <= init_cnt + 1'b1;
          end
        cfgpin_pkg::CFG_USER: cfg_state <= cfgpin_pkg::CFG_USER;
        default: cfg_state <= cfgpin_pkg::CFG_RESET;
      endcase
    end
  end

  // Pin drive decisions
  logic in_user;
  logic [3:0] opt_on;
  assign in_user = (cfg_state == cfgpin_pkg::CFG_USER);
  assign opt_on = {options[cfgpin_pkg::OPT_GLOBAL_CLR], options[cfgpin_pkg::OPT_GLOBAL_OE],
                   options[cfgpin_pkg::OPT_INIT_DONE], options[cfgpin_pkg::OPT_STARTUP_CLK]};

  // Optional pins: dedicated function when on, user I/O when off
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      opt_pin_out <= '0;
      opt_pin_oe <= '0;
      opt_pin_pullup <= 4'hF;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        opt_pin_pullup[i] <= ~in_user & ~opt_on[i];
        opt_pin_out[i] <= opt_on[i] ? 1'b0 : opt_io_out[i];
        opt_pin_oe[i] <= ~opt_on[i] & in_user & opt_io_oe[i] & ~global_oe_off;
      end
      // Init-done only ever pulls low between option load and end of start-up
      if (opt_on[cfgpin_pkg::PIN_INIT_DONE])
        opt_pin_oe[cfgpin_pkg::PIN_INIT_DONE] <= options_loaded & ~in_user
                                                & s_cfg_start_n;
    end
  end

  // General user I/O with global output enable override
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      io_out <= '0;
      io_oe <= '0;
    end
    else
    begin
      io_out <= io_out_reg;
      io_oe <= (in_user & ~global_oe_off) ? io_oe_reg : '0;
    end
  end

  // Active-serial pins: driven idle in configuration, floated in user mode on request
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      as_out <= cfgpin_pkg::AS_IDLE_LEVEL;
      as_oe <= 3'h7;
      config_serial_in_en <= 1'b1;
      user_mode <= 1'b0;
    end
    else
    begin
      as_out <= cfgpin_pkg::AS_IDLE_LEVEL;
      as_oe <= (in_user && options[cfgpin_pkg::OPT_AS_TRISTATE]) ? 3'h0 : 3'h7;
      config_serial_in_en <= ~(in_user & options[cfgpin_pkg::OPT_AS_TRISTATE]);
      user_mode <= in_user;
    end
  end

  // Scan port controller: mode sampled on rise, state moves on fall
  cfgpin_pkg::cfgpin_tap_t tap_state;
  logic tms_smp;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      tms_smp <= 1'b1;
    else if (tck_rise)
      tms_smp <= s_tms;
  end

  // Controller state transitions
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      tap_state <= cfgpin_pkg::TAP_RESET;
    else if (!s_trst_n)
      tap_state <= cfgpin_pkg::TAP_RESET;
    else if (tck_fall)
    begin
      case (tap_state)
        cfgpin_pkg::TAP_RESET:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_RESET : cfgpin_pkg::TAP_IDLE;
        cfgpin_pkg::TAP_IDLE:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_SEL_DR : cfgpin_pkg::TAP_IDLE;
        cfgpin_pkg::TAP_SEL_DR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_SEL_IR : cfgpin_pkg::TAP_CAP_DR;
        cfgpin_pkg::TAP_CAP_DR, cfgpin_pkg::TAP_SH_DR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_EX1_DR : cfgpin_pkg::TAP_SH_DR;
        cfgpin_pkg::TAP_EX1_DR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_UPD_DR : cfgpin_pkg::TAP_PA_DR;
        cfgpin_pkg::TAP_PA_DR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_EX2_DR : cfgpin_pkg::TAP_PA_DR;
        cfgpin_pkg::TAP_EX2_DR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_UPD_DR : cfgpin_pkg::TAP_SH_DR;
        cfgpin_pkg::TAP_SEL_IR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_RESET : cfgpin_pkg::TAP_CAP_IR;
        cfgpin_pkg::TAP_CAP_IR, cfgpin_pkg::TAP_SH_IR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_EX1_IR : cfgpin_pkg::TAP_SH_IR;
        cfgpin_pkg::TAP_EX1_IR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_UPD_IR : cfgpin_pkg::TAP_PA_IR;
        cfgpin_pkg::TAP_PA_IR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_EX2_IR : cfgpin_pkg::TAP_PA_IR;
        cfgpin_pkg::TAP_EX2_IR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_UPD_IR : cfgpin_pkg::TAP_SH_IR;
        cfgpin_pkg::TAP_UPD_DR, cfgpin_pkg::TAP_UPD_IR:
          tap_state <= tms_smp ? cfgpin_pkg::TAP_SEL_DR : cfgpin_pkg::TAP_IDLE;
        default: tap_state <= cfgpin_pkg::TAP_RESET;
      endcase
    end
  end

  // Shift registers: capture and shift on rise, update on fall
  logic [IR_W-1:0] ir_shift;
  logic [DR_W-1:0] dr_shift;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ir_shift <= '0;
      dr_shift <= '0;
      ir_hold <= '0;
      dr_hold <= '0;
    end
    else if (tck_rise)
    begin
      case (tap_state)
        cfgpin_pkg::TAP_CAP_IR: ir_shift <= {{(IR_W-2){1'b0}}, cfgpin_pkg::IR_CAPTURE};
        cfgpin_pkg::TAP_SH_IR: ir_shift <= {s_tdi, ir_shift[IR_W-1:1]};
        cfgpin_pkg::TAP_CAP_DR: dr_shift <= dr_hold;
        cfgpin_pkg::TAP_SH_DR: dr_shift <= {s_tdi, dr_shift[DR_W-1:1]};
        default: dr_shift <= dr_shift;
      endcase
    end
    else if (tck_fall && tap_state == cfgpin_pkg::TAP_UPD_IR)
      ir_hold <= ir_shift;
    else if (tck_fall && tap_state == cfgpin_pkg::TAP_UPD_DR)
      dr_hold <= dr_shift;
  end

  // Shift state entered at the coming fall, so the first bit drives with the enable
  logic ir_shift_next;
  logic dr_shift_next;
  assign ir_shift_next = ~tms_smp & ((tap_state == cfgpin_pkg::TAP_CAP_IR)
                       | (tap_state == cfgpin_pkg::TAP_SH_IR)
                       | (tap_state == cfgpin_pkg::TAP_EX2_IR));
  assign dr_shift_next = ~tms_smp & ((tap_state == cfgpin_pkg::TAP_CAP_DR)
                       | (tap_state == cfgpin_pkg::TAP_SH_DR)
                       | (tap_state == cfgpin_pkg::TAP_EX2_DR));

  // Test data out changes on the fall, floats outside shift states and in scan reset
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (!s_trst_n)
      tdo_oe <= 1'b0;
    else if (tck_fall)
    begin
      tdo_out <= ir_shift_next ? ir_shift[0] : dr_shift[0];
      tdo_oe <= ir_shift_next | dr_shift_next;
    end
  end
endmodule

// ---- sim/cfgpin_monitor.sv ----
`timescale 1ns/1ps
module cfgpin_monitor (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // Init-done driver of the device
  input logic done_out,
  input logic done_oe,
  // Resolved pin and user-mode flag
  output logic done_level,
  output logic user_seen
);
  logic level_q;
  // Open-drain wire held high by the board pull-up
  assign done_level = done_oe ? done_out : 1'h1;
  // A low-to-high edge on the wire marks entry to user mode
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      level_q <= 1'h1;
      user_seen <= 1'h0;
    end
    else
    begin
      level_q <= done_level;
      if (!done_level)
        user_seen <= 1'h0;
      else if (!level_q)
        user_seen <= 1'h1;
    end
  end
endmodule

// ---- sim/cfgpin_sva.sv ----
`timescale 1ns/1ps
module cfgpin_sva #(
  parameter int IO_W = 8
) (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // Bus handshake
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  // Configuration and pins
  input logic config_start_n,
  input logic [3:0] opt_pin_out,
  input logic [3:0] opt_pin_oe,
  input logic [IO_W-1:0] io_oe,
  input logic tck,
  input logic trst_n,
  input logic tdo_oe,
  input logic user_mode
);
  // One clock domain for every check
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_done_never_high: assert property (opt_pin_oe[1] |-> !opt_pin_out[1])
    else $error("init-done driven high");
  a_done_float_idle: assert property (!config_start_n [*4] |-> !opt_pin_oe[1])
    else $error("init-done driven while start held low");
  a_restart_exit: assert property ($fell(config_start_n) |-> ##[1:6] !user_mode)
    else $error("user mode kept after start went low");
  a_done_low_cfg: assert property ($rose(opt_pin_oe[1]) |-> !user_mode)
    else $error("init-done pulled low in user mode");
  a_release_user: assert property ($rose(user_mode) |-> !opt_pin_oe[1])
    else $error("init-done not released at user mode");
  a_io_float_cfg: assert property (!user_mode && !$fell(user_mode) |-> io_oe == '0)
    else $error("user I/O driven during configuration");
  a_tdo_in_reset: assert property (!trst_n [*4] |-> !tdo_oe)
    else $error("scan output driven in scan reset");
  a_tdo_on_fall: assert property ($changed(tdo_oe) |-> !$past(tck))
    else $error("scan output moved outside a falling edge");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_bus_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low for more than a cycle");
endmodule

bind cfgpin_top cfgpin_sva #(.IO_W(IO_W)) u_sva (
  .ref_clk(ref_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .config_start_n(config_start_n),
  .opt_pin_out(opt_pin_out), .opt_pin_oe(opt_pin_oe), .io_oe(io_oe), .tck(tck),
  .trst_n(trst_n), .tdo_oe(tdo_oe), .user_mode(user_mode)
);

// ---- sim/config_control_pins_test.sv ----
`timescale 1ns/1ps
module config_control_pins_test;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, serial_en, tdo_out, tdo_oe, user_mode, done_level, user_seen, so;
  logic config_start_n = 1'h0;
  logic [2:0] as_out, as_oe;
  logic [3:0] pin_drv = 4'hC;
  logic [3:0] opt_pin_out, opt_pin_oe, opt_pin_pullup;
  logic [7:0] io_out, io_oe;
  logic tck = 1'h0, tms = 1'h1, tdi = 1'h1, trst_n = 1'h1;
  int n_mismatch = 0;
  int comparisons = 0;

  // Clock
  always #12.5 ref_clk = ~ref_clk;

  cfgpin_top dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .config_start_n(config_start_n),
    .config_serial_in(1'h1), .as_out(as_out), .as_oe(as_oe), .config_serial_in_en(serial_en),
    .opt_pin_in({pin_drv[3:2], done_level, pin_drv[0]}), .opt_pin_out(opt_pin_out),
    .opt_pin_oe(opt_pin_oe), .opt_pin_pullup(opt_pin_pullup), .io_in(8'h3C),
    .io_out(io_out), .io_oe(io_oe), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .user_mode(user_mode)
  );

  cfgpin_monitor mon_u (
    .ref_clk(ref_clk), .rstn(rstn), .done_out(opt_pin_out[1]), .done_oe(opt_pin_oe[1]),
    .done_level(done_level), .user_seen(user_seen)
  );

  // Cycle wait
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer, held until wait request is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'h0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20)
      n_mismatch++;
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge ref_clk);
  endtask

  // Restart configuration with the given options up to data complete
  task automatic cfg_run(input logic [31:0] opts);
    config_start_n <= 1'h0;
    clk(6);
    chk(opt_pin_oe[1], 1'h0);
    config_start_n <= 1'h1;
    clk(4);
    chk(opt_pin_oe[1], 1'h0);
    bus(1'h1, cfgpin_pkg::OFF_OPTIONS, opts);
    bus(1'h1, cfgpin_pkg::OFF_CMD, 32'h1);
    clk(2);
    chk({opt_pin_oe[1], opt_pin_out[1]}, 2'h2);
    bus(1'h1, cfgpin_pkg::OFF_CMD, 32'h2);
  endtask

  // Bounded wait for user mode
  task automatic wait_user();
    int n;
    n = 0;
    while (user_mode !== 1'h1 && n < 400)
    begin
      clk(1);
      n++;
    end
    chk(user_mode, 1'h1);
  endtask

  // Plain configuration, options off except init-done
  task automatic t_basic();
    chk(opt_pin_pullup, 4'hF);
    chk(opt_pin_oe, 4'h0);
    bus(1'h0, 6'h3C, 32'h0);
    chk(q, 32'h0);
    cfg_run(32'h2);
    wait_user();
    clk(2);
    chk({opt_pin_oe[1], user_seen}, 2'h1);
    chk({as_oe, serial_en, as_out}, 7'h7E);
    bus(1'h1, cfgpin_pkg::OFF_OPT_IO, 32'h11);
    clk(2);
    chk({opt_pin_oe, opt_pin_out}, 8'h11);
    bus(1'h1, cfgpin_pkg::OFF_IO_OE, 32'h0F);
    pin_drv[2] <= 1'h0;
    clk(5);
    chk(io_oe, 8'h0F);
    pin_drv[2] <= 1'h1;
  endtask

  // Initialization timed by the user start-up clock only
  task automatic t_startup_clock();
    cfg_run(32'h3);
    clk(300);
    chk(user_mode, 1'h0);
    repeat (40)
    begin
      pin_drv[0] <= !pin_drv[0];
      clk(4);
    end
    wait_user();
    clk(2);
    chk(user_seen, 1'h1);
  endtask

  // Serial pin float, global output enable and global clear
  task automatic t_global_pins();
    cfg_run(32'h1E);
    wait_user();
    clk(2);
    chk({as_oe, serial_en}, 4'h0);
    bus(1'h1, cfgpin_pkg::OFF_IO_OE, 32'hFF);
    bus(1'h1, cfgpin_pkg::OFF_IO_OUT, 32'h5A);
    clk(2);
    chk({io_oe, io_out}, 16'hFF5A);
    pin_drv[2] <= 1'h0;
    clk(5);
    chk(io_oe, 8'h00);
    pin_drv[2] <= 1'h1;
    clk(5);
    chk(io_oe, 8'hFF);
    pin_drv[3] <= 1'h0;
    clk(5);
    chk({io_oe, io_out}, 16'h0);
    bus(1'h0, cfgpin_pkg::OFF_IO_OUT, 32'h0);
    chk(q, 32'h0);
    pin_drv[3] <= 1'h1;
    clk(5);
    bus(1'h1, cfgpin_pkg::OFF_IO_OUT, 32'hA5);
    clk(2);
    chk(io_out, 8'hA5);
  endtask

  // One scan clock period, mode and data set while the clock is low
  task automatic tap(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    clk(5);
    so = tdo_out;
    tck <= 1'h1;
    clk(5);
    tck <= 1'h0;
  endtask

  // Shift a word through the data path and read it back
  task automatic t_scan();
    logic [31:0] pat;
    pat = 32'hA5C30F96;
    trst_n <= 1'h0;
    clk(6);
    chk(tdo_oe, 1'h0);
    trst_n <= 1'h1;
    tap(1'h0, 1'h0);
    tap(1'h1, 1'h0);
    tap(1'h0, 1'h0);
    tap(1'h0, 1'h0);
    for (int i = 0; i < 32; i++)
    begin
      if (i == 4)
        chk(tdo_oe, 1'h1);
      tap(i == 31, pat[i]);
    end
    tap(1'h1, 1'h0);
    tap(1'h0, 1'h0);
    clk(6);
    chk(tdo_oe, 1'h0);
    bus(1'h0, cfgpin_pkg::OFF_SCAN_DR, 32'h0);
    chk(q, pat);
    // Second pass: the captured word leaves on test data out while its inverse enters
    tap(1'h1, 1'h0);
    tap(1'h0, 1'h0);
    tap(1'h0, 1'h0);
    for (int i = 0; i < 32; i++)
    begin
      tap(i == 31, !pat[i]);
      chk(so, pat[i]);
    end
    tap(1'h1, 1'h0);
    tap(1'h0, 1'h0);
    clk(6);
    bus(1'h0, cfgpin_pkg::OFF_SCAN_DR, 32'h0);
    chk(q, ~pat);
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clk(12);
    rstn <= 1'h1;
    clk(1);
    t_basic();
    t_startup_clock();
    t_global_pins();
    t_scan();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial
  begin
    clk(20000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
